// [sntrx_regs.svh]
// register map, field positions, reset values and timing counts of the
// sent receive block; assumes inclusion from the package, whose macros the design files use
`ifndef SNTRX_REGS_SVH
`define SNTRX_REGS_SVH
`define SNTRX_ADDR_W 8
`define SNTRX_NCH 2
`define SNTRX_GLOBAL_CONTROL 8'h00
`define SNTRX_CH_BASE 8'h10
`define SNTRX_CH_STRIDE 8'h10
`define SNTRX_CFG_OFS 4'h0
`define SNTRX_STATUS_OFS 4'h4
`define SNTRX_IRQ_CLR_OFS 4'h8
`define SNTRX_IRQ_EN_OFS 4'hc
`define SNTRX_GBL_EN_BIT 0
`define SNTRX_CFG_PAUSE_BIT 0
`define SNTRX_CFG_SUCC_BIT 1
`define SNTRX_CFG_NIB_LSB 4
`define SNTRX_CFG_NIB_MSB 6
`define SNTRX_CFG_RESET 32'h0000_0060
`define SNTRX_ST_EDGES 0
`define SNTRX_ST_NIBVAL 1
`define SNTRX_ST_CRC 2
`define SNTRX_ST_CALLEN 3
`define SNTRX_ST_OFLW 4
`define SNTRX_ST_PDIAG 5
`define SNTRX_ST_MSGRDY 6
`define SNTRX_NSTAT 7
`define SNTRX_DATA_LSB 8
`define SNTRX_CAL_TICKS 56
`define SNTRX_NIB_MIN_TICKS 12
`define SNTRX_NIB_MAX_TICKS 27
`define SNTRX_PAUSE_MIN_TICKS 12
`define SNTRX_PAUSE_MAX_TICKS 768
`define SNTRX_CAL_TOL_DIV 64
`define SNTRX_CRC_SEED 4'h5
`define SNTRX_IDX_CAL 4'hf
`endif

// [sntrx_pkg.sv]
// types of the sent receive block; assumes sntrx_regs.svh next to it
package sntrx_pkg;
`include "sntrx_regs.svh"
	typedef enum logic [2:0] {
		SNTRX_IDLE,
		SNTRX_WAIT_CAL,
		SNTRX_NIBBLES,
		SNTRX_PAUSE
	} sntrx_state_t;
endpackage

// [sntrx_channel.sv]
// one sent receive channel: pulse measurement, message state machine,
// error events; assumes a synchronised falling-edge pulse from the top
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module sntrx_channel import sntrx_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic fall_i,
	input wire logic pause_en_i,
	input wire logic succ_sel_i,
	input wire logic [2:0] nib_cnt_i,
	input wire logic oflw_block_i,
	output logic [`SNTRX_NSTAT-1:0] event_o,
	output logic [23:0] data_o
);
	sntrx_state_t state;
	logic [15:0] period;
	logic [15:0] tick_len;
	logic [15:0] prev_cal;
	logic [3:0] nib_idx;
	logic [3:0] crc;
	logic [23:0] shreg;
	logic [4:0] edges;

	// a pulse counts as calibration within 1/64 of the last calibration, or above 48 clocks before the first
	function automatic logic is_cal(input logic [15:0] p,
		input logic [15:0] ref_cal);
		logic [15:0] tol;
		tol = ref_cal / 16'(`SNTRX_CAL_TOL_DIV);
		is_cal = (ref_cal == 16'h0000) ? (p > 16'h0030) :
			(p + tol >= ref_cal) && (p <= ref_cal + tol);
	endfunction

	function automatic logic [3:0] crc_step(input logic [3:0] c,
		input logic [3:0] d);
		logic [3:0] x;
		x = c ^ d;
		crc_step = {x[2:0], 1'b0} ^ (x[3] ? 4'hd : 4'h0);
	endfunction

	// nibble value from period in ticks; tick_len is ticks scaled by 56
	logic [15:0] ticks;
	logic [4:0] nib_raw;
	logic nib_ok;
	always_comb begin
		ticks = (tick_len == 16'h0000) ? 16'h0000 :
			16'((32'(period) * 32'(`SNTRX_CAL_TICKS)) / 32'(tick_len));
		nib_raw = 5'(ticks - 16'(`SNTRX_NIB_MIN_TICKS));
		nib_ok = (ticks >= 16'(`SNTRX_NIB_MIN_TICKS)) &&
			(ticks <= 16'(`SNTRX_NIB_MAX_TICKS));
	end

	logic cal_seen;
	assign cal_seen = is_cal(period, prev_cal);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !run_i || fall_i)
			period <= 16'h0001;
		else if (period != 16'hffff)
			period <= period + 16'h0001;
	end

	// per-channel machine, independent of any other channel
	always_ff @(posedge sys_clk_i) begin
		event_o <= '0;
		if (rst_i || !run_i) begin
			state <= SNTRX_IDLE; // first partial message dropped
			tick_len <= 16'h0000;
			prev_cal <= 16'h0000;
			nib_idx <= 4'h0;
			crc <= `SNTRX_CRC_SEED;
			shreg <= 24'h000000;
			edges <= 5'h00;
			data_o <= 24'h000000;
		end else if (oflw_block_i && state == SNTRX_NIBBLES && fall_i) begin
			event_o[`SNTRX_ST_OFLW] <= 1'b1;
			state <= SNTRX_WAIT_CAL;
		end else if (fall_i) begin
			edges <= edges + 5'h01;
			case (state)
			SNTRX_IDLE: begin
				if (cal_seen) begin
					tick_len <= period;
					prev_cal <= period;
					state <= SNTRX_NIBBLES;
					nib_idx <= 4'h0;
					edges <= 5'h00;
					crc <= `SNTRX_CRC_SEED;
				end
			end
			SNTRX_WAIT_CAL: begin
				if (cal_seen) begin
					// pause and cal read as two cal pulses, no edge between
					if (edges == 5'h00)
						event_o[`SNTRX_ST_EDGES] <= 1'b1;
					tick_len <= period;
					prev_cal <= period;
					state <= SNTRX_NIBBLES;
					nib_idx <= 4'h0;
					edges <= 5'h00;
					crc <= `SNTRX_CRC_SEED;
				end else
					edges <= 5'h00;
			end
			SNTRX_NIBBLES: begin
				if (nib_idx == `SNTRX_IDX_CAL) begin
					// slot after the crc nibble must hold a calibration
					if (cal_seen) begin
						tick_len <= period;
						prev_cal <= period;
						nib_idx <= 4'h0;
						edges <= 5'h00;
						crc <= `SNTRX_CRC_SEED;
					end else if (ticks > 16'(`SNTRX_NIB_MAX_TICKS)) begin
						// calibration fails validity; boundary lost
						event_o[`SNTRX_ST_CALLEN] <= 1'b1;
						event_o[`SNTRX_ST_EDGES] <= 1'b1;
						state <= SNTRX_WAIT_CAL;
					end else begin
						// nibble where the calibration belongs
						event_o[`SNTRX_ST_NIBVAL] <= 1'b1;
						event_o[`SNTRX_ST_EDGES] <= 1'b1;
						state <= SNTRX_WAIT_CAL;
					end
				end else if (cal_seen && nib_idx != 4'h0) begin
					// early cal: fewer edges than expected
					event_o[`SNTRX_ST_EDGES] <= !succ_sel_i ? 1'b0 : 1'b1;
					tick_len <= period;
					prev_cal <= period;
					nib_idx <= 4'h0;
					edges <= 5'h00;
					crc <= `SNTRX_CRC_SEED;
				end else if (!nib_ok) begin
					// a pause taken as a nibble lands here too
					event_o[`SNTRX_ST_NIBVAL] <= 1'b1;
					event_o[`SNTRX_ST_EDGES] <= 1'b1;
					state <= SNTRX_WAIT_CAL;
				end else if (nib_idx == 4'h0) begin
					nib_idx <= 4'h1; // status nibble
				end else if (nib_idx <= {1'b0, nib_cnt_i}) begin
					shreg <= {shreg[19:0], nib_raw[3:0]};
					crc <= crc_step(crc, nib_raw[3:0]);
					nib_idx <= nib_idx + 4'h1;
				end else begin
					// crc nibble
					if (crc_step(crc, 4'h0) != nib_raw[3:0]) begin
						event_o[`SNTRX_ST_CRC] <= 1'b1;
						state <= SNTRX_WAIT_CAL;
					end else begin
						data_o <= shreg;
						event_o[`SNTRX_ST_MSGRDY] <= 1'b1;
						state <= pause_en_i ? SNTRX_PAUSE : SNTRX_NIBBLES;
					end
					nib_idx <= `SNTRX_IDX_CAL;
					edges <= 5'h00;
				end
			end
			SNTRX_PAUSE: begin
				// a nibble-sized pulse here means a late pause
				if (nib_ok) begin
					event_o[`SNTRX_ST_NIBVAL] <= 1'b1;
					event_o[`SNTRX_ST_PDIAG] <= 1'b1;
					event_o[`SNTRX_ST_EDGES] <= 1'b1;
					state <= SNTRX_WAIT_CAL;
				end else
					state <= SNTRX_NIBBLES;
				edges <= 5'h00;
			end
			default: state <= SNTRX_IDLE;
			endcase
		end
	end
endmodule

// [sntrx_top.sv]
// Behaviour
// - a per-channel config bit at 1 makes the channel expect a pause after the data nibbles.
// - a nibble value or crc error sends the channel to wait for the next calibration pulse.
// - pause and calibration seen as back-to-back calibration pulses flag an edge-count error.
// - a calibration pulse failing validity sets calib length error and an edge-count error.
// - fewer edges than expected make the pause read as a nibble, giving a nibble value error.
// - more edges than expected make a late pause give nibble value and pause diag errors.
// - a config bit at 1 selects the high-latency check with edge count; 0 skips that check.
// - an overflow may force the wait-for-calibration state, where can then fire; the overflow pulse never meets a falling edge, so no overflow is flagged.
// - a global bit at 1 enables the receiver; the first partial message is lost.
// - error flags stay set until software clears them.
// top of the sent receiver: register port, pin synchronisers, channels,
// sticky status and interrupt; assumes a single 25 MHz clock
`timescale 1ns/10ps
module sntrx_top import sntrx_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [`SNTRX_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [`SNTRX_NCH-1:0] sent_rx_i,
	output logic irq_o
);
	logic module_global_enable;
	logic [31:0] channel_config [`SNTRX_NCH];
	logic [`SNTRX_NSTAT-1:0] channel_status [`SNTRX_NCH];
	logic [`SNTRX_NSTAT-1:0] irq_en [`SNTRX_NCH];
	logic [23:0] ch_data [`SNTRX_NCH];
	logic [`SNTRX_NSTAT-1:0] ch_event [`SNTRX_NCH];
	logic [`SNTRX_NCH-1:0] sync_a;
	logic [`SNTRX_NCH-1:0] sync_b;
	logic [`SNTRX_NCH-1:0] sync_c;
	logic [`SNTRX_NCH-1:0] unread;

	function automatic logic ch_hit(input logic [`SNTRX_ADDR_W-1:0] a,
		input int ch, input logic [3:0] ofs);
		ch_hit = a == 8'(`SNTRX_CH_BASE + ch * `SNTRX_CH_STRIDE + ofs);
	endfunction

	// pins cross into the clock domain through two flops before use
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sync_a <= '1;
			sync_b <= '1;
			sync_c <= '1;
		end else begin
			sync_a <= sent_rx_i;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			module_global_enable <= 1'b0;
		else if (wr_i && addr_i == `SNTRX_GLOBAL_CONTROL)
			module_global_enable <= wdata_i[`SNTRX_GBL_EN_BIT];
	end

	genvar g;
	generate
		for (g = 0; g < `SNTRX_NCH; g++) begin : gch
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					channel_config[g] <= `SNTRX_CFG_RESET;
					irq_en[g] <= '0;
				end else if (wr_i) begin
					if (ch_hit(addr_i, g, `SNTRX_CFG_OFS))
						channel_config[g] <= wdata_i;
					if (ch_hit(addr_i, g, `SNTRX_IRQ_EN_OFS))
						irq_en[g] <= wdata_i[`SNTRX_NSTAT-1:0];
				end
			end

			// overflow: a new message completes before the last was read
			always_ff @(posedge sys_clk_i) begin
				if (rst_i)
					unread[g] <= 1'b0;
				else if (ch_event[g][`SNTRX_ST_MSGRDY])
					unread[g] <= 1'b1;
				else if (rd_i && ch_hit(addr_i, g, `SNTRX_STATUS_OFS))
					unread[g] <= 1'b0;
			end

			// sticky flags; a set in the clear cycle wins
			always_ff @(posedge sys_clk_i) begin
				if (rst_i)
					channel_status[g] <= '0;
				else if (wr_i && ch_hit(addr_i, g, `SNTRX_IRQ_CLR_OFS))
					channel_status[g] <= (channel_status[g] &
						~wdata_i[`SNTRX_NSTAT-1:0]) | ch_event[g];
				else
					channel_status[g] <= channel_status[g] | ch_event[g];
			end

			sntrx_channel u_ch (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.run_i(module_global_enable),
				.fall_i(sync_c[g] & ~sync_b[g]),
				.pause_en_i(channel_config[g][`SNTRX_CFG_PAUSE_BIT]),
				.succ_sel_i(channel_config[g][`SNTRX_CFG_SUCC_BIT]),
				.nib_cnt_i(channel_config[g][`SNTRX_CFG_NIB_MSB:`SNTRX_CFG_NIB_LSB]),
				.oflw_block_i(unread[g] & ch_event[g][`SNTRX_ST_MSGRDY]),
				.event_o(ch_event[g]),
				.data_o(ch_data[g])
			);
		end
	endgenerate

	logic [31:0] next_rdata;
	logic next_irq;
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_irq = 1'b0;
		if (addr_i == `SNTRX_GLOBAL_CONTROL)
			next_rdata = {31'h0, module_global_enable};
		for (int c = 0; c < `SNTRX_NCH; c++) begin
			next_irq = next_irq | (|(channel_status[c] & irq_en[c]));
			if (ch_hit(addr_i, c, `SNTRX_CFG_OFS))
				next_rdata = channel_config[c];
			if (ch_hit(addr_i, c, `SNTRX_STATUS_OFS))
				next_rdata = {ch_data[c], 1'b0, channel_status[c]};
			if (ch_hit(addr_i, c, `SNTRX_IRQ_EN_OFS))
				next_rdata = {25'h0, irq_en[c]};
		end
	end

	// read data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
			irq_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
			irq_o <= next_irq;
		end
	end
endmodule

// [sntrx_top_monitor.sv]
// checker of the sent receiver register port and interrupt
// assumes a bind to sntrx_top; sees its ports only
`timescale 1ns/10ps
module sntrx_top_monitor import sntrx_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [`SNTRX_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [`SNTRX_NCH-1:0] sent_rx_i,
	input wire logic irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [6:0] cfg0, cfg1;
	logic gen, ever, ien0, ien1;
	// shadow of what software wrote, so read-back can be judged
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cfg0 <= 7'h60;
			cfg1 <= 7'h60;
			gen <= 1'b0;
			ever <= 1'b0;
			ien0 <= 1'b0;
			ien1 <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == 8'h10) cfg0 <= wdata_i[6:0];
			if (addr_i == 8'h20) cfg1 <= wdata_i[6:0];
			if (addr_i == 8'h00) gen <= wdata_i[0];
			if (addr_i == 8'h00 && wdata_i[0]) ever <= 1'b1;
			if (addr_i == 8'h1c) ien0 <= |wdata_i[6:0];
			if (addr_i == 8'h2c) ien1 <= |wdata_i[6:0];
		end
	end
	a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (rd_i && addr_i == 8'h04 |=>
		rdata_o == 32'h0) else $error("unmapped read not zero");
	a_clear_reads_zero: assert property (rd_i && addr_i[3:0] == 4'h8 |=>
		rdata_o == 32'h0) else $error("clear register read not zero");
	a_cfg0_readback: assert property (rd_i && addr_i == 8'h10 |=>
		rdata_o[6:0] == cfg0) else $error("config 0 read-back wrong");
	a_cfg1_readback: assert property (rd_i && addr_i == 8'h20 |=>
		rdata_o[6:0] == cfg1) else $error("config 1 read-back wrong");
	a_enable_readback: assert property (rd_i && addr_i == 8'h00 |=>
		rdata_o[0] == gen) else $error("global enable read-back wrong");
	a_status_before_enable: assert property (rd_i && !ever &&
		(addr_i == 8'h14 || addr_i == 8'h24) |=> rdata_o == 32'h0)
		else $error("status set before enable");
	a_irq_masked_low: assert property (!ien0 && !ien1 |=> !irq_o)
		else $error("interrupt high with all enables off");
endmodule
bind sntrx_top sntrx_top_monitor u_sntrx_top_monitor (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.sent_rx_i(sent_rx_i), .irq_o(irq_o));

// [sntrx_sensor.sv]
// sent sensor model: pulses of whole ticks on one line
// assumes a free-running system clock; the line idles high
`timescale 1ns/10ps
module sntrx_sensor #(parameter int TK = 3) (
	input wire logic sys_clk_i,
	output logic line_o
);
	initial line_o = 1'b1;
	// each pulse opens with a falling edge and a 5-tick low phase
	task pulse(input int t);
		@(posedge sys_clk_i);
		line_o <= 1'b0;
		repeat (5 * TK) @(posedge sys_clk_i);
		line_o <= 1'b1;
		repeat ((t - 5) * TK - 1) @(posedge sys_clk_i);
	endtask
endmodule

// [tb.sv]
// self-checking bench of the sent receiver
// assumes sntrx_sensor on channel 0; channel 1 stays idle high
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin \
	errors++; $display("BAD %0t got %h", $time, g); end end
module tb;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0] addr_i = 8'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o, q;
	logic [1:0] sent_rx_i;
	logic irq_o, line;
	int errors = 0, checks = 0, seed = 32'h9e22b2f6;
	always #20 sys_clk_i = ~sys_clk_i;
	assign sent_rx_i = {1'b1, line};
	sntrx_top u_sntrx_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .sent_rx_i(sent_rx_i), .irq_o(irq_o));
	sntrx_sensor u_sntrx_sensor (.sys_clk_i(sys_clk_i), .line_o(line));
	// crc over the data nibbles: seed 5, feedback pattern 4'hd
	function automatic logic [3:0] crc_next(input logic [3:0] c,
		input logic [3:0] d);
		logic [3:0] x;
		x = c ^ d;
		return {x[2:0], 1'b0} ^ (x[3] ? 4'hd : 4'h0);
	endfunction
	function automatic logic [31:0] bit_of(input int b);
		return 32'h1 << b;
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 q = rdata_o;
	endtask
	// calibration, then seven random nibbles and the crc nibble; index bad is too long
	task msg(input int bad);
		int v;
		logic [3:0] c;
		c = `SNTRX_CRC_SEED;
		u_sntrx_sensor.pulse(56);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed) & 15;
			if (i == 7)
				v = crc_next(c, 4'h0);
			else if (i > 0)
				c = crc_next(c, 4'(v));
			u_sntrx_sensor.pulse(i == bad ? 40 : 12 + v);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int c = 1; c < 3; c++) begin
			rd(8'(8'h10 * c)); `CHK(q, 32'h60)
			rd(8'(8'h10 * c + 4)); `CHK(q, 32'h0)
		end
		rd(8'h00); `CHK(q, 32'h0)
		rd(8'h04); `CHK(q, 32'h0)
		rd(8'h18); `CHK(q, 32'h0)
		msg(2);
		u_sntrx_sensor.pulse(56);
		rd(8'h14); `CHK(q, 32'h0)
		$display("test reset and disabled done");
		wr(8'h10, 32'h63);
		rd(8'h10); `CHK(q[6:0], 7'h63)
		wr(8'h10, 32'h60);
		wr(8'h1c, bit_of(`SNTRX_ST_NIBVAL));
		wr(8'h00, 32'h1);
		msg(9);
		msg(9);
		msg(2);
		u_sntrx_sensor.pulse(56);
		rd(8'h14); `CHK(q[`SNTRX_ST_NIBVAL], 1'b1)
		`CHK(irq_o, 1'b1)
		rd(8'h24); `CHK(q[6:0], 7'h0)
		wr(8'h1c, 32'h0);
		repeat (2) @(posedge sys_clk_i);
		`CHK(irq_o, 1'b0)
		wr(8'h1c, bit_of(`SNTRX_ST_NIBVAL));
		repeat (2) @(posedge sys_clk_i);
		`CHK(irq_o, 1'b1)
		rd(8'h14); `CHK(q[`SNTRX_ST_NIBVAL], 1'b1)
		wr(8'h18, 32'h7f);
		rd(8'h14); `CHK(q[`SNTRX_ST_NIBVAL], 1'b0)
		repeat (2) @(posedge sys_clk_i);
		`CHK(irq_o, 1'b0)
		$display("test nibble error and interrupt done");
		msg(9);
		msg(9);
		u_sntrx_sensor.pulse(70);
		u_sntrx_sensor.pulse(56);
		rd(8'h14); `CHK(q[`SNTRX_ST_CALLEN], 1'b1)
		`CHK(q[`SNTRX_ST_EDGES], 1'b1)
		$display("test calibration length done");
		give_verdict;
	end
endmodule
